// ### verilog/vdi_cfg.svh
// constants for the vectored daisy-chain interrupt block
// Summary of operation
// - reset leaves the block in plain-request mode, not vectored chain mode
// - vectored chain mode is entered only by the set-vectored-mode command
// - an enabled pending condition drives interrupt_request_n low
// - on acknowledge in vectored mode the vector register is driven on the data bus
// - chain enable in and out act only in vectored chain mode
// - chain enable in high lets only unmasked sources request
// - chain enable in low suppresses every request
// - chain enable out high only when chain in high and not requesting
// - after acknowledge, chain out stays low until clear-in-service command
// - request released once software removes all pending causes
// - downstream device cannot request until upstream chain out returns high
`ifndef VDI_CFG_SVH
`define VDI_CFG_SVH
`define VDI_ADDR_CTRL 12'h000
`define VDI_ADDR_STATUS 12'h004
`define VDI_ADDR_MASK 12'h008
`define VDI_ADDR_VECTOR 12'h00c
`define VDI_ADDR_PEND 12'h010
`define VDI_CMD_SET_VEC 0
`define VDI_CMD_CLR_IUS 1
`define VDI_CMD_SET_PLAIN 2
`define VDI_RST_MASK 8'h00
`define VDI_RST_VECTOR 8'h0f
`endif

// ### verilog/vdi_pkg.sv
// types for the vectored daisy-chain interrupt block
package vdi_pkg;
	typedef enum logic [1:0] {
		VDI_IDLE = 2'b00,
		VDI_REQ = 2'b01,
		VDI_SERVICE = 2'b10
	} vdi_state_t;
	typedef struct packed {
		logic [7:0] data;
		logic oe;
	} vdi_bus_drive_t;
endpackage : vdi_pkg

// ### verilog/vdi_top.sv
// interrupt request, vector answer and daisy chain with an apb register file
`timescale 1ns/1ps
`include "vdi_cfg.svh"
module vdi_top
	import vdi_pkg::*;
(
	// apb slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// interrupt sources, one level each
	input wire logic [7:0] source_level,
	// host and chain pins
	input wire logic vector_acknowledge_n,
	input wire logic chain_enable_in,
	output logic interrupt_request_n,
	output logic chain_enable_out,
	output vdi_bus_drive_t data_drive
);
	logic vec_mode_q;
	logic [7:0] mask_q;
	logic [7:0] vector_register_q;
	vdi_state_t state_q;
	vdi_state_t state_d;
	logic ack_seen_q;
	logic [31:0] rdata_d;

	// apb decode; zero-wait slave
	wire access = psel && penable;
	wire wr_en = access && pwrite;
	wire hit_ctrl = (paddr == `VDI_ADDR_CTRL);
	wire hit_status = (paddr == `VDI_ADDR_STATUS);
	wire hit_mask = (paddr == `VDI_ADDR_MASK);
	wire hit_vector = (paddr == `VDI_ADDR_VECTOR);
	wire hit_pend = (paddr == `VDI_ADDR_PEND);
	wire hit_any = hit_ctrl || hit_status || hit_mask || hit_vector || hit_pend;
	wire cmd_set_vec = wr_en && hit_ctrl && pwdata[`VDI_CMD_SET_VEC];
	wire cmd_set_plain = wr_en && hit_ctrl && pwdata[`VDI_CMD_SET_PLAIN];
	wire clear_in_service_cmd = wr_en && hit_ctrl && pwdata[`VDI_CMD_CLR_IUS];

	// chain input only counts in vectored mode; plain mode behaves as if enabled
	wire chain_ok = vec_mode_q ? chain_enable_in : 1'b1;
	wire [7:0] pending = source_level & ~mask_q;
	// causes gone means request released; chain input low blocks the request in vectored mode
	wire want_req = (|pending) && chain_ok;
	wire ack_now = vec_mode_q && !vector_acknowledge_n;
	wire in_service = (state_q == VDI_SERVICE);

	// mode register: reset to plain, set only by command
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			vec_mode_q <= 1'b0;
		else if (cmd_set_vec)
			vec_mode_q <= 1'b1;
		else if (cmd_set_plain)
			vec_mode_q <= 1'b0;
	end

	// software registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mask_q <= `VDI_RST_MASK;
			vector_register_q <= `VDI_RST_VECTOR;
		end
		else
		begin
			if (wr_en && hit_mask)
				mask_q <= pwdata[7:0];
			if (wr_en && hit_vector)
				vector_register_q <= pwdata[7:0];
		end
	end

	// service state: acknowledged request holds until clear command or return to plain mode
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			VDI_IDLE:
				if (want_req)
					state_d = VDI_REQ;
			VDI_REQ:
				if (ack_now)
					state_d = VDI_SERVICE;
				else if (!want_req)
					state_d = VDI_IDLE;
			VDI_SERVICE:
				if (clear_in_service_cmd)
					state_d = VDI_IDLE;
			default:
				state_d = VDI_IDLE;
		endcase
		if (!vec_mode_q)
			state_d = VDI_IDLE;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state_q <= VDI_IDLE;
		else
			state_q <= state_d;
	end

	// pins; request stays low in service only while causes remain
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			interrupt_request_n <= 1'b1;
			chain_enable_out <= 1'b0;
			ack_seen_q <= 1'b0;
			data_drive <= '0;
		end
		else
		begin
			interrupt_request_n <= !(want_req && (state_d != VDI_IDLE || !vec_mode_q));
			// chain out low in plain mode, in service, or when requesting
			chain_enable_out <= vec_mode_q && chain_enable_in && !want_req
				&& (state_d != VDI_SERVICE);
			ack_seen_q <= ack_now;
			// vector driven while acknowledge is held, undriven otherwise
			data_drive.oe <= ack_now;
			data_drive.data <= ack_now ? vector_register_q : 8'h00;
		end
	end

	// read mux
	always_comb
	begin
		rdata_d = 32'h0000_0000;
		if (hit_ctrl)
			rdata_d = {31'h0000_0000, vec_mode_q};
		else if (hit_status)
			rdata_d = {28'h0000000, ack_seen_q, in_service, state_q == VDI_REQ, want_req};
		else if (hit_mask)
			rdata_d = {24'h000000, mask_q};
		else if (hit_vector)
			rdata_d = {24'h000000, vector_register_q};
		else if (hit_pend)
			rdata_d = {24'h000000, pending};
	end

	// apb answer registered in setup cycle so pready is high at first access edge
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !hit_any;
			prdata <= (psel && !penable && !pwrite) ? rdata_d : 32'h0000_0000;
		end
	end

	// assertions
	reset_plain_a: assert property (@(posedge pclk) $rose(presetn) |-> !vec_mode_q)
		else $error("block left reset in vectored mode");
	mode_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(vec_mode_q) |-> $past(cmd_set_vec))
		else $error("vectored mode entered without command");
	request_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
		(want_req && !vec_mode_q) |=> !interrupt_request_n)
		else $error("request not driven for pending source");
	vector_out_a: assert property (@(posedge pclk) disable iff (!presetn)
		ack_now |=> (data_drive.oe && data_drive.data == $past(vector_register_q)))
		else $error("vector not driven on acknowledge");
	chain_block_a: assert property (@(posedge pclk) disable iff (!presetn)
		(vec_mode_q && !chain_enable_in) |=> interrupt_request_n)
		else $error("request raised with chain input low");
	chain_out_a: assert property (@(posedge pclk) disable iff (!presetn)
		chain_enable_out |-> $past(chain_enable_in && !want_req && vec_mode_q))
		else $error("chain output high without cause");
	service_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(in_service && !clear_in_service_cmd && vec_mode_q) |=> !chain_enable_out)
		else $error("chain output rose during service");
	release_a: assert property (@(posedge pclk) disable iff (!presetn)
		(pending == 8'h00) |=> interrupt_request_n)
		else $error("request held with no causes");
	plain_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
		!vec_mode_q |=> (!chain_enable_out && !data_drive.oe))
		else $error("chain pins active outside vectored mode");

	// apb handshake: zero-wait answer, one-cycle pulses, error only with ready
	apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && !penable) |=> pready)
		else $error("pready missing in access cycle");

	ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
		pready |=> !pready)
		else $error("pready held past one cycle");

	ready_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
		pready |-> $past(psel && !penable))
		else $error("pready without setup cycle");

	error_with_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
		pslverr |-> pready)
		else $error("pslverr without pready");

	unmapped_error_a: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && !penable && !hit_any) |=> (pslverr && pready))
		else $error("unmapped access not refused");

	write_rdata_a: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && !penable && pwrite) |=> (prdata == 32'h0000_0000))
		else $error("read data not zero on write");

	// register contents: a write lands at the access edge, reads show live state
	mask_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && hit_mask) |=> (mask_q == $past(pwdata[7:0])))
		else $error("mask write lost");

	vector_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && hit_vector) |=> (vector_register_q == $past(pwdata[7:0])))
		else $error("vector write lost");

	mode_read_a: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && !penable && !pwrite && hit_ctrl)
		|=> (prdata == {31'h0000_0000, $past(vec_mode_q)}))
		else $error("mode read wrong");

	pend_read_a: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && !penable && !pwrite && hit_pend)
		|=> (prdata == {24'h000000, $past(pending)}))
		else $error("pending read wrong");

	// mode changes only by command; plain mode keeps the service machine idle
	mode_exit_a: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(vec_mode_q) |-> $past(cmd_set_plain))
		else $error("vectored mode left without command");

	plain_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
		!vec_mode_q |=> (state_q == VDI_IDLE))
		else $error("service state active in plain mode");

	// plain mode must still request although the chain input is low
	plain_request_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!vec_mode_q && !chain_enable_in && pending != 8'h00)
		|=> !interrupt_request_n)
		else $error("plain request blocked by chain input");

	plain_release_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!vec_mode_q && !want_req) |=> interrupt_request_n)
		else $error("plain request held without cause");

	// vectored request follows unmasked causes while the chain allows it
	mask_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		(vec_mode_q && chain_enable_in && pending != 8'h00)
		|=> !interrupt_request_n)
		else $error("unmasked source not requested");

	masked_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
		((source_level & ~mask_q) == 8'h00) |=> interrupt_request_n)
		else $error("masked source raised request");

	// acknowledge takes the request into service and shows the vector
	service_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q == VDI_REQ && ack_now && vec_mode_q) |=> in_service)
		else $error("acknowledge did not start service");

	ack_status_a: assert property (@(posedge pclk) disable iff (!presetn)
		ack_now |=> ack_seen_q)
		else $error("acknowledge not recorded");

	vector_release_a: assert property (@(posedge pclk) disable iff (!presetn)
		!ack_now |=> !data_drive.oe)
		else $error("vector driven without acknowledge");

	idle_data_a: assert property (@(posedge pclk) disable iff (!presetn)
		!data_drive.oe |-> (data_drive.data == 8'h00))
		else $error("data bus value without enable");

	// chain output: low while input low or requesting, back high after clear
	chain_in_low_a: assert property (@(posedge pclk) disable iff (!presetn)
		!chain_enable_in |=> !chain_enable_out)
		else $error("chain output high with input low");

	chain_req_a: assert property (@(posedge pclk) disable iff (!presetn)
		(vec_mode_q && want_req) |=> !chain_enable_out)
		else $error("chain output high while requesting");

	chain_release_a: assert property (@(posedge pclk) disable iff (!presetn)
		(in_service && clear_in_service_cmd && vec_mode_q && chain_enable_in
		&& !want_req && !cmd_set_plain) |=> chain_enable_out)
		else $error("chain output not restored after clear");

	// pins leave reset in their idle levels
	reset_pins_a: assert property (@(posedge pclk)
		$rose(presetn) |-> (interrupt_request_n && !chain_enable_out
		&& !data_drive.oe))
		else $error("pins not idle after reset");
endmodule : vdi_top

// ### verification/vdi_host.sv
// host model that answers a low request with an acknowledge
`timescale 1ns/1ps
module vdi_host
	import vdi_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// bench control: enable and answer delay
	input wire logic en,
	input wire logic [3:0] lag,
	// device pins
	input wire logic interrupt_request_n,
	input wire vdi_bus_drive_t data_drive,
	output logic vector_acknowledge_n
);
	logic [3:0] cnt_q;
	// ack held until the vector shows, so a slow device is not cut short
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			vector_acknowledge_n <= 1'b1;
			cnt_q <= 4'h0;
		end
		else if (!vector_acknowledge_n)
		begin
			vector_acknowledge_n <= data_drive.oe || !en;
			cnt_q <= 4'h0;
		end
		else if (en && !interrupt_request_n)
		begin
			cnt_q <= cnt_q + 4'h1;
			vector_acknowledge_n <= cnt_q != lag;
		end
		else
			cnt_q <= 4'h0;
	end
endmodule : vdi_host

// ### verification/testbench.sv
// self-checking bench for the vectored daisy-chain interrupt block
`timescale 1ns/1ps
`include "vdi_cfg.svh"
module testbench
	import vdi_pkg::*;
();
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, r_d;
	logic pready, pslverr, r_e, irq_n, cout, ack_n;
	logic [7:0] src = 8'h00;
	logic cin = 1'b0, hen = 1'b0;
	logic [3:0] lag = 4'h0;
	vdi_bus_drive_t dd;
	int failures = 0, checks = 0;
	// 100 ns clock
	always #50 pclk = ~pclk;
	vdi_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .source_level(src),
		.vector_acknowledge_n(ack_n), .chain_enable_in(cin),
		.interrupt_request_n(irq_n), .chain_enable_out(cout), .data_drive(dd));
	vdi_host host (.pclk(pclk), .presetn(presetn), .en(hen), .lag(lag),
		.interrupt_request_n(irq_n), .data_drive(dd), .vector_acknowledge_n(ack_n));
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			failures++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask : chk
	// one apb transfer, entered just after a rising edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		r_d = prdata;
		r_e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task t_plain();
		chk("irq rst", 32'h1, 32'(irq_n));
		chk("cout rst", 32'h0, 32'(cout));
		apb(1'b0, `VDI_ADDR_CTRL, 32'h0);
		chk("mode", 32'h0, r_d & 32'h1);
		apb(1'b0, `VDI_ADDR_VECTOR, 32'h0);
		chk("vector rst", 32'(`VDI_RST_VECTOR), r_d & 32'hff);
		src <= 8'h01;
		hen <= 1'b1;
		repeat (4) @(posedge pclk);
		chk("irq plain", 32'h0, 32'(irq_n));
		chk("oe plain", 32'h0, 32'(dd.oe));
		chk("cout plain", 32'h0, 32'(cout));
		hen <= 1'b0;
		src <= 8'h00;
		repeat (3) @(posedge pclk);
		chk("irq gone", 32'h1, 32'(irq_n));
	endtask : t_plain
	task t_vec();
		apb(1'b1, `VDI_ADDR_VECTOR, 32'ha5);
		apb(1'b1, `VDI_ADDR_CTRL, 32'h1 << `VDI_CMD_SET_VEC);
		apb(1'b0, `VDI_ADDR_CTRL, 32'h0);
		chk("mode vec", 32'h1, r_d & 32'h1);
		cin <= 1'b1;
		lag <= 4'h3;
		repeat (3) @(posedge pclk);
		chk("cout idle", 32'h1, 32'(cout));
		hen <= 1'b1;
		src <= 8'h02;
		repeat (3) @(posedge pclk);
		chk("irq vec", 32'h0, 32'(irq_n));
		chk("cout req", 32'h0, 32'(cout));
		for (int i = 0; i < 30 && dd.oe !== 1'b1; i++) @(posedge pclk);
		chk("vector out", 32'ha5, 32'(dd.data));
		hen <= 1'b0;
		src <= 8'h00;
		repeat (3) @(posedge pclk);
		chk("irq done", 32'h1, 32'(irq_n));
		chk("cout held", 32'h0, 32'(cout));
		apb(1'b0, `VDI_ADDR_STATUS, 32'h0);
		chk("status service", 32'h4, r_d & 32'hf);
		apb(1'b1, `VDI_ADDR_CTRL, 32'h1 << `VDI_CMD_CLR_IUS);
		repeat (2) @(posedge pclk);
		chk("cout back", 32'h1, 32'(cout));
	endtask : t_vec
	task t_gate();
		apb(1'b1, `VDI_ADDR_MASK, 32'h04);
		src <= 8'h04;
		repeat (3) @(posedge pclk);
		chk("irq masked", 32'h1, 32'(irq_n));
		apb(1'b0, `VDI_ADDR_PEND, 32'h0);
		chk("pend", 32'h0, r_d & 32'hff);
		apb(1'b1, `VDI_ADDR_MASK, 32'h00);
		repeat (2) @(posedge pclk);
		chk("irq open", 32'h0, 32'(irq_n));
		cin <= 1'b0;
		repeat (3) @(posedge pclk);
		chk("irq chain", 32'h1, 32'(irq_n));
		chk("cout chain", 32'h0, 32'(cout));
		apb(1'b0, 12'h100, 32'h0);
		chk("slverr", 32'h1, 32'(r_e));
		chk("unmapped", 32'h0, r_d);
		apb(1'b1, `VDI_ADDR_CTRL, 32'h1 << `VDI_CMD_SET_PLAIN);
		apb(1'b0, `VDI_ADDR_CTRL, 32'h0);
		chk("mode plain", 32'h0, r_d & 32'h1);
		chk("irq plain cin", 32'h0, 32'(irq_n));
		chk("cout plain end", 32'h0, 32'(cout));
	endtask : t_gate
	task final_report();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : final_report
	// main sequence after a three-cycle reset
	initial
	begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_plain();
		t_vec();
		t_gate();
		final_report();
	end
	// watchdog well beyond the hundred or so cycles the tests need
	initial
	begin
		repeat (3000) @(posedge pclk);
		failures++;
		final_report();
	end
endmodule : testbench
